/* File: hw/tbl_access_pkg.sv */
package tbl_access_pkg;

    // ----------------------------------------------------------------
    // Register addresses in special function register space.
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_RESET_CAUSE = 12'hfd0;
    localparam logic [11:0] ADDR_TABLE_LATCH = 12'hfd4;
    localparam logic [11:0] ADDR_PTR_LOW = 12'hfd5;
    localparam logic [11:0] ADDR_PTR_HIGH = 12'hfd6;
    localparam logic [11:0] ADDR_PTR_UPPER = 12'hfd7;

    // ----------------------------------------------------------------
    // Pointer geometry and reset-cause field layout.
    // ----------------------------------------------------------------
    localparam int PTR_W = 22;
    localparam int LOW_W = 21;
    localparam int UPPER_W = 6;
    localparam logic [LOW_W-1:0] PTR_STEP = 21'h000001;
    localparam int BIT_IRQ_LEVEL = 7;
    localparam int BIT_LONG_PROG = 6;
    localparam int BIT_UNUSED = 5;
    localparam int BIT_RESET_OP = 4;
    localparam int BIT_WDT = 3;
    localparam int BIT_PWRDN = 2;
    localparam int BIT_POR = 1;
    localparam int BIT_BROWNOUT = 0;
    localparam logic [7:0] RESET_CAUSE_POR_VALUE = 8'h1c;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Types.
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PTR_KEEP,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } ptr_mode_t;

    typedef struct packed {
        logic write;
        ptr_mode_t mode;
    } tbl_op_t;

    typedef struct packed {
        logic master_clear_pin_reset;
        logic brownout_reset;
        logic reset_op;
        logic wdt_timeout;
        logic watchdog_clear_op;
        logic sleep_op;
    } reset_events_t;

    typedef struct packed {
        logic read;
        logic ext_write;
        logic prog;
        logic [PTR_W-1:0] addr;
        logic [15:0] data;
    } pm_cmd_t;

endpackage

/* File: hw/byte_pointer.sv */
`timescale 1ns/1ns
`default_nettype none
module byte_pointer
    import tbl_access_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] byte_we,
    input wire logic [7:0] wdata,
    input wire logic step,
    input wire tbl_access_pkg::ptr_mode_t mode,
    output logic [PTR_W-1:0] ptr,
    output logic [PTR_W-1:0] access_addr
);
    logic [LOW_W-1:0] plus_one;
    logic [LOW_W-1:0] minus_one;
    logic [LOW_W-1:0] next_low;

    assign plus_one = ptr[LOW_W-1:0] + PTR_STEP;
    assign minus_one = ptr[LOW_W-1:0] - PTR_STEP;
    assign next_low = (mode == PTR_POST_DEC) ? minus_one
                    : (mode == PTR_KEEP) ? ptr[LOW_W-1:0] : plus_one;
    assign access_addr = (mode == PTR_PRE_INC) ?
        {ptr[PTR_W-1], plus_one} : ptr;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ptr <= '0;
        else if (step)
            ptr <= {ptr[PTR_W-1], next_low};
        else
        begin
            if (byte_we[0])
                ptr[7:0] <= wdata;
            if (byte_we[1])
                ptr[15:8] <= wdata;
            if (byte_we[2])
                ptr[PTR_W-1:16] <= wdata[UPPER_W-1:0];
        end
    end

    property p_top_kept;
        @(posedge clk) disable iff (reset)
        step |=> ptr[PTR_W-1] == $past(ptr[PTR_W-1]);
    endproperty
    a_top_kept: assert property (p_top_kept)
        else $error("Pointer step changed the top bit.");

    property p_post_inc;
        @(posedge clk) disable iff (reset)
        (step && mode == PTR_POST_INC) |=>
            ptr[LOW_W-1:0] == LOW_W'($past(ptr[LOW_W-1:0]) + PTR_STEP);
    endproperty
    a_post_inc: assert property (p_post_inc)
        else $error("Post increment gave a wrong pointer.");

    property p_post_dec;
        @(posedge clk) disable iff (reset)
        (step && mode == PTR_POST_DEC) |=>
            ptr[LOW_W-1:0] == LOW_W'($past(ptr[LOW_W-1:0]) - PTR_STEP);
    endproperty
    a_post_dec: assert property (p_post_dec)
        else $error("Post decrement gave a wrong pointer.");

endmodule
`default_nettype wire

/* File: hw/reset_cause_reg.sv */
`timescale 1ns/1ns
`default_nettype none
module reset_cause_reg
    import tbl_access_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic we,
    input wire logic [7:0] wdata,
    input wire tbl_access_pkg::reset_events_t ev,
    output logic [7:0] value
);
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            value <= RESET_CAUSE_POR_VALUE;
        else
        begin
            if (we)
            begin
                value[BIT_IRQ_LEVEL] <= wdata[BIT_IRQ_LEVEL];
                value[BIT_LONG_PROG] <= value[BIT_LONG_PROG]
                    | wdata[BIT_LONG_PROG];
                value[BIT_RESET_OP:BIT_BROWNOUT] <=
                    wdata[BIT_RESET_OP:BIT_BROWNOUT];
            end
            if (ev.master_clear_pin_reset)
                value[BIT_LONG_PROG] <= 1'b0;
            if (ev.brownout_reset)
                value[BIT_BROWNOUT] <= 1'b0;
            if (ev.reset_op)
                value[BIT_RESET_OP] <= 1'b0;
            if (ev.sleep_op)
            begin
                value[BIT_WDT] <= 1'b1;
                value[BIT_PWRDN] <= 1'b0;
            end
            if (ev.watchdog_clear_op)
            begin
                value[BIT_WDT] <= 1'b1;
                value[BIT_PWRDN] <= 1'b1;
            end
            if (ev.wdt_timeout)
                value[BIT_WDT] <= 1'b0;
            value[BIT_UNUSED] <= 1'b0;
        end
    end

    property p_long_sticky;
        @(posedge clk) disable iff (reset)
        ($past(value[BIT_LONG_PROG]) && !$past(ev.master_clear_pin_reset))
            |-> value[BIT_LONG_PROG];
    endproperty
    a_long_sticky: assert property (p_long_sticky)
        else $error("Long program enable cleared without master clear.");

    property p_wdt_flag;
        @(posedge clk) disable iff (reset)
        ev.wdt_timeout |=> !value[BIT_WDT] ##1 1'b1;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag)
        else $error("Watchdog time-out did not clear its flag.");

    property p_sleep_flag;
        @(posedge clk) disable iff (reset)
        (ev.sleep_op && !ev.watchdog_clear_op) |=> !value[BIT_PWRDN];
    endproperty
    a_sleep_flag: assert property (p_sleep_flag)
        else $error("Sleep did not clear the power-down flag.");

    property p_reset_op_flag;
        @(posedge clk) disable iff (reset)
        ev.reset_op |=> !value[BIT_RESET_OP];
    endproperty
    a_reset_op_flag: assert property (p_reset_op_flag)
        else $error("Reset instruction did not clear its flag.");

endmodule
`default_nettype wire

/* File: hw/table_access_reset_control.sv */
`timescale 1ns/1ns
`default_nettype none
module table_access_reset_control
    import tbl_access_pkg::*;
#(
    parameter int INTERNAL_BYTES = 32768
)
(
    // Clock and power-on reset.
    input wire logic CLK,
    input wire logic RESET,
    // Special function register access.
    input wire logic [11:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Table operation request from the core.
    input wire logic TBL_REQ,
    input wire tbl_access_pkg::tbl_op_t TBL_OP,
    output logic TBL_BUSY,
    output logic TBL_DONE,
    // Reset sources, instruction events and programming voltage.
    input wire tbl_access_pkg::reset_events_t RESET_EVENTS,
    input wire logic VPP_PRESENT,
    // Program memory side.
    output tbl_access_pkg::pm_cmd_t PM_CMD,
    input wire logic [7:0] PM_RDATA,
    // Core control.
    output logic IRQ_PRIORITY_MODE
);
    import tbl_access_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks.
    // ----------------------------------------------------------------
    if (INTERNAL_BYTES < 2 || INTERNAL_BYTES > (1 << LOW_W))
    begin : g_bad_size
        $error("INTERNAL_BYTES must lie between 2 and the pointer span.");
    end

    localparam logic [LOW_W:0] INTERNAL_LIMIT = (LOW_W+1)'(INTERNAL_BYTES);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ_ISSUE,
        ST_READ_TAKE
    } seq_state_t;

    seq_state_t state;
    seq_state_t next_state;
    logic [7:0] table_data_latch;
    logic [7:0] holding;
    logic [7:0] reset_cause_control;
    logic [PTR_W-1:0] program_byte_pointer;
    logic [PTR_W-1:0] access_addr;

    // ----------------------------------------------------------------
    // Register decode.
    // ----------------------------------------------------------------
    wire hit_cause = (SFR_ADDR == ADDR_RESET_CAUSE);
    wire hit_latch = (SFR_ADDR == ADDR_TABLE_LATCH);
    wire hit_low = (SFR_ADDR == ADDR_PTR_LOW);
    wire hit_high = (SFR_ADDR == ADDR_PTR_HIGH);
    wire hit_upper = (SFR_ADDR == ADDR_PTR_UPPER);
    wire cause_we = SFR_WR && hit_cause;
    wire latch_we = SFR_WR && hit_latch;
    wire [2:0] ptr_we = {3{SFR_WR}} & {hit_upper, hit_high, hit_low};
    wire [7:0] upper_read =
        {{(8-UPPER_W){1'b0}}, program_byte_pointer[PTR_W-1:16]};
    wire [7:0] cause_read =
        reset_cause_control & ~(8'h01 << BIT_UNUSED);
    wire [7:0] read_mux = hit_cause ? cause_read
                        : hit_latch ? table_data_latch
                        : hit_low ? program_byte_pointer[7:0]
                        : hit_high ? program_byte_pointer[15:8]
                        : hit_upper ? upper_read : READ_ZERO;

    // ----------------------------------------------------------------
    // Table operation decode.
    // ----------------------------------------------------------------
    wire take_op = TBL_REQ && (state == ST_IDLE);
    wire take_read = take_op && !TBL_OP.write;
    wire take_write = take_op && TBL_OP.write;
    wire config_space = access_addr[PTR_W-1];
    wire internal_target = config_space ||
        ({1'b0, access_addr[LOW_W-1:0]} < INTERNAL_LIMIT);
    wire odd_byte = access_addr[0];
    wire long_enable = reset_cause_control[BIT_LONG_PROG];
    wire short_write = take_write && internal_target && !odd_byte;
    wire long_write = take_write && internal_target && odd_byte
        && long_enable && VPP_PRESENT;
    wire ext_write = take_write && !internal_target;

    // ----------------------------------------------------------------
    // Submodules.
    // ----------------------------------------------------------------
    byte_pointer u_pointer (
        .clk(CLK),
        .reset(RESET),
        .byte_we(ptr_we),
        .wdata(SFR_WDATA),
        .step(take_op),
        .mode(TBL_OP.mode),
        .ptr(program_byte_pointer),
        .access_addr(access_addr)
    );

    reset_cause_reg u_cause (
        .clk(CLK),
        .reset(RESET),
        .we(cause_we),
        .wdata(SFR_WDATA),
        .ev(RESET_EVENTS),
        .value(reset_cause_control)
    );

    // ----------------------------------------------------------------
    // Sequencer.
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (take_read)
                    next_state = ST_READ_ISSUE;
            ST_READ_ISSUE:
                next_state = ST_READ_TAKE;
            ST_READ_TAKE:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state <= ST_IDLE;
            TBL_BUSY <= 1'b0;
            TBL_DONE <= 1'b0;
        end
        else
        begin
            state <= next_state;
            TBL_BUSY <= (next_state != ST_IDLE);
            TBL_DONE <= take_write || (state == ST_READ_TAKE);
        end
    end

    // ----------------------------------------------------------------
    // Program memory command.
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            PM_CMD <= '0;
        else
        begin
            PM_CMD.read <= take_read;
            PM_CMD.ext_write <= ext_write;
            PM_CMD.prog <= long_write;
            if (take_op)
                PM_CMD.addr <= access_addr;
            if (ext_write)
                PM_CMD.data <= {8'h00, table_data_latch};
            else if (long_write)
                PM_CMD.data <= {table_data_latch, holding};
        end
    end

    // ----------------------------------------------------------------
    // Latch, holding register and register read data.
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            table_data_latch <= '0;
            holding <= '0;
            SFR_RDATA <= '0;
            IRQ_PRIORITY_MODE <= 1'b0;
        end
        else
        begin
            if (state == ST_READ_TAKE)
                table_data_latch <= PM_RDATA;
            else if (latch_we)
                table_data_latch <= SFR_WDATA;
            if (short_write)
                holding <= table_data_latch;
            SFR_RDATA <= SFR_RD ? read_mux : READ_ZERO;
            IRQ_PRIORITY_MODE <= reset_cause_control[BIT_IRQ_LEVEL];
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    property p_unused_zero;
        @(posedge CLK) disable iff (RESET)
        (SFR_RD && hit_cause) |=> !SFR_RDATA[BIT_UNUSED];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused reset-cause bit read as one.");

    property p_priority_mode;
        @(posedge CLK) disable iff (RESET)
        (cause_we && SFR_WDATA[BIT_IRQ_LEVEL]) |=> ##1 IRQ_PRIORITY_MODE;
    endproperty
    a_priority_mode: assert property (p_priority_mode)
        else $error("Priority mode did not follow the enable bit.");

    property p_prog_needs_enable;
        @(posedge CLK) disable iff (RESET)
        PM_CMD.prog |-> $past(long_enable) && $past(VPP_PRESENT);
    endproperty
    a_prog_needs_enable: assert property (p_prog_needs_enable)
        else $error("Programming started without long enable.");

    property p_ext_write;
        @(posedge CLK) disable iff (RESET)
        (take_write && !internal_target) |=>
            PM_CMD.ext_write && !PM_CMD.prog;
    endproperty
    a_ext_write: assert property (p_ext_write)
        else $error("External table write was not issued.");

    property p_even_short;
        @(posedge CLK) disable iff (RESET)
        (take_write && internal_target && !odd_byte) |=>
            !PM_CMD.prog && holding == $past(table_data_latch);
    endproperty
    a_even_short: assert property (p_even_short)
        else $error("Even table write was not a short write.");

    property p_read_byte;
        @(posedge CLK) disable iff (RESET)
        PM_CMD.read |=> ##1 (table_data_latch == $past(PM_RDATA) && TBL_DONE);
    endproperty
    a_read_byte: assert property (p_read_byte)
        else $error("Table read did not load the latch.");

    property p_pre_inc_addr;
        @(posedge CLK) disable iff (RESET)
        (take_op && TBL_OP.mode == PTR_PRE_INC) |=>
            PM_CMD.addr[LOW_W-1:0] ==
            LOW_W'($past(program_byte_pointer[LOW_W-1:0]) + PTR_STEP);
    endproperty
    a_pre_inc_addr: assert property (p_pre_inc_addr)
        else $error("Pre-increment access used a wrong address.");

    property p_read_busy;
        @(posedge CLK) disable iff (RESET)
        take_read |=> TBL_BUSY [*2] ##1 !TBL_BUSY;
    endproperty
    a_read_busy: assert property (p_read_busy)
        else $error("Table read busy window is wrong.");

    property p_config_internal;
        @(posedge CLK) disable iff (RESET)
        (take_write && config_space) |=> !PM_CMD.ext_write;
    endproperty
    a_config_internal: assert property (p_config_internal)
        else $error("Configuration space write went to external memory.");

    property p_short_only;
        @(posedge CLK) disable iff (RESET)
        (take_write && internal_target && !long_enable) |=>
            !PM_CMD.prog && !PM_CMD.ext_write;
    endproperty
    a_short_only: assert property (p_short_only)
        else $error("Internal write issued without long enable.");

    property p_access_addr;
        @(posedge CLK) disable iff (RESET)
        take_op |=> PM_CMD.addr == $past(access_addr);
    endproperty
    a_access_addr: assert property (p_access_addr)
        else $error("Table access used a wrong byte address.");

    property p_latch_load;
        @(posedge CLK) disable iff (RESET)
        (latch_we && state != ST_READ_TAKE) |=>
            table_data_latch == $past(SFR_WDATA);
    endproperty
    a_latch_load: assert property (p_latch_load)
        else $error("Table data latch missed a register write.");

    property p_cause_read;
        @(posedge CLK) disable iff (RESET)
        (SFR_RD && hit_cause) |=> SFR_RDATA == $past(cause_read);
    endproperty
    a_cause_read: assert property (p_cause_read)
        else $error("Reset-cause read returned a wrong value.");

    property p_upper_zero;
        @(posedge CLK) disable iff (RESET)
        (SFR_RD && hit_upper) |=> SFR_RDATA[7:UPPER_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("Pointer upper byte read unused bits as one.");

    property p_long_data;
        @(posedge CLK) disable iff (RESET)
        PM_CMD.prog |->
            PM_CMD.data == {$past(table_data_latch), $past(holding)};
    endproperty
    a_long_data: assert property (p_long_data)
        else $error("Long write data did not pair latch and holding.");

    c_read: cover property (@(posedge CLK) disable iff (RESET)
        PM_CMD.read ##2 TBL_DONE);
    c_prog: cover property (@(posedge CLK) disable iff (RESET)
        PM_CMD.prog);
    c_ext: cover property (@(posedge CLK) disable iff (RESET)
        PM_CMD.ext_write);
    c_config: cover property (@(posedge CLK) disable iff (RESET)
        take_op && config_space);

endmodule
`default_nettype wire

/* File: verification/pm_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pm_model
(
    // Clock.
    input wire logic clk,
    // Command from the block and the byte handed back.
    input wire tbl_access_pkg::pm_cmd_t cmd,
    output logic [7:0] rdata,
    // Record of what the block asked for.
    output logic [7:0] n_write,
    output tbl_access_pkg::pm_cmd_t last_write,
    output logic [21:0] last_rd_addr
);
    import tbl_access_pkg::*;

    // ----------------------------------------------------------------
    // Read model: any byte address answers with its low byte xor 5a, outside reads toggle.
    // ----------------------------------------------------------------
    initial
    begin
        rdata = 8'h00;
        n_write = 8'h00;
        last_write = '0;
        last_rd_addr = 22'h000000;
    end

    always @(posedge clk)
    begin
        if (cmd.read)
        begin
            rdata <= cmd.addr[7:0] ^ 8'h5a;
            last_rd_addr <= cmd.addr;
        end
        else
        begin
            rdata <= ~rdata;
        end
        if (cmd.ext_write || cmd.prog)
        begin
            n_write <= n_write + 8'h01;
            last_write <= cmd;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tbl_access_pkg::*;

    // ----------------------------------------------------------------
    // Signals and instances.
    // ----------------------------------------------------------------
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [11:0] SFR_ADDR = 12'h000;
    logic SFR_WR = 1'b0;
    logic SFR_RD = 1'b0;
    logic [7:0] SFR_WDATA = 8'h00;
    logic [7:0] SFR_RDATA;
    logic TBL_REQ = 1'b0;
    tbl_op_t TBL_OP = '0;
    logic TBL_BUSY;
    logic TBL_DONE;
    reset_events_t RESET_EVENTS = '0;
    logic VPP_PRESENT = 1'b1;
    pm_cmd_t PM_CMD;
    logic [7:0] PM_RDATA;
    logic IRQ_PRIORITY_MODE;
    logic [7:0] n_write;
    pm_cmd_t last_write;
    logic [21:0] last_rd_addr;
    int num_errors = 0;
    int n_tests = 0;

    table_access_reset_control #(.INTERNAL_BYTES(256)) i_dut (
        .CLK(CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
        .TBL_REQ(TBL_REQ), .TBL_OP(TBL_OP), .TBL_BUSY(TBL_BUSY),
        .TBL_DONE(TBL_DONE), .RESET_EVENTS(RESET_EVENTS),
        .VPP_PRESENT(VPP_PRESENT), .PM_CMD(PM_CMD), .PM_RDATA(PM_RDATA),
        .IRQ_PRIORITY_MODE(IRQ_PRIORITY_MODE));

    pm_model i_mem (.clk(CLK), .cmd(PM_CMD), .rdata(PM_RDATA),
        .n_write(n_write), .last_write(last_write),
        .last_rd_addr(last_rd_addr));

    initial
    begin
        forever #50 CLK = ~CLK;
    end

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic results();
        $display("errors %0d, comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge CLK);
        SFR_WR <= 1'b1;
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        @(posedge CLK);
        SFR_WR <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge CLK);
        SFR_RD <= 1'b1;
        SFR_ADDR <= a;
        @(posedge CLK);
        SFR_RD <= 1'b0;
        @(negedge CLK);
        chk($sformatf("register %h", a), {16'h0000, exp}, {16'h0, SFR_RDATA});
    endtask

    task automatic set_ptr(input logic [21:0] p);
        wr(ADDR_PTR_LOW, p[7:0]);
        wr(ADDR_PTR_HIGH, p[15:8]);
        wr(ADDR_PTR_UPPER, {2'b00, p[21:16]});
    endtask

    task automatic chk_ptr(input logic [21:0] p);
        rd(ADDR_PTR_LOW, p[7:0]);
        rd(ADDR_PTR_HIGH, p[15:8]);
        rd(ADDR_PTR_UPPER, {2'b00, p[21:16]});
    endtask

    task automatic op(input logic w, input ptr_mode_t m);
        int n_busy;
        int n_done;
        n_busy = 0;
        n_done = 0;
        @(posedge CLK);
        TBL_REQ <= 1'b1;
        TBL_OP <= '{write: w, mode: m};
        @(posedge CLK);
        TBL_REQ <= 1'b0;
        repeat (8)
        begin
            @(negedge CLK);
            if (TBL_DONE === 1'b1)
                n_done++;
            if (TBL_BUSY === 1'b1)
                n_busy++;
        end
        if (n_done == 0)
        begin
            $display("unexpected table done expected 1 seen 0");
            num_errors++;
            results();
        end
        chk("done pulses", 24'h1, 24'(n_done));
        chk("busy cycles", w ? 24'h0 : 24'h2, 24'(n_busy));
    endtask

    task automatic twrite(input logic [21:0] p, input logic [7:0] d,
        input logic [7:0] n_exp);
        set_ptr(p);
        wr(ADDR_TABLE_LATCH, d);
        op(1'b1, PTR_KEEP);
        chk("write strobes", {16'h0, n_exp}, {16'h0, n_write});
    endtask

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        rd(ADDR_RESET_CAUSE, 8'h1c);
        rd(ADDR_TABLE_LATCH, 8'h00);
        rd(12'h000, 8'h00);
        chk_ptr(22'h000000);
    endtask

    task automatic t_reads();
        ptr_mode_t m [4] = '{PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC,
            PTR_KEEP};
        logic [21:0] p;
        logic [21:0] a;
        p = 22'h3fffff;
        set_ptr(p);
        foreach (m[i])
        begin
            a = {p[21], p[20:0] + (m[i] == PTR_PRE_INC ? 21'h1 : 21'h0)};
            if (m[i] == PTR_POST_DEC)
                p = {p[21], p[20:0] - 21'h1};
            else if (m[i] != PTR_KEEP)
                p = {p[21], p[20:0] + 21'h1};
            wr(ADDR_TABLE_LATCH, 8'h00);
            op(1'b0, m[i]);
            chk("read address", {2'b00, a}, {2'b00, last_rd_addr});
            rd(ADDR_TABLE_LATCH, a[7:0] ^ 8'h5a);
            chk_ptr(p);
        end
    endtask

    task automatic t_short_writes();
        twrite(22'h000010, 8'h11, 8'h00);
        twrite(22'h000011, 8'h22, 8'h00);
        twrite(22'h000100, 8'h33, 8'h01);
        chk("external data", 24'h000033, {8'h0, last_write.data});
    endtask

    task automatic t_register();
        wr(ADDR_RESET_CAUSE, 8'hff);
        rd(ADDR_RESET_CAUSE, 8'hdf);
        chk("priority mode", 24'h1, {23'h0, IRQ_PRIORITY_MODE});
        wr(ADDR_RESET_CAUSE, 8'h00);
        rd(ADDR_RESET_CAUSE, 8'h40);
        chk("priority mode", 24'h0, {23'h0, IRQ_PRIORITY_MODE});
    endtask

    task automatic t_long_write();
        twrite(22'h000010, 8'h44, 8'h01);
        twrite(22'h000011, 8'h55, 8'h02);
        chk("long data", 24'h005544, {8'h0, last_write.data});
        chk("long address", 24'h000011, {2'b0, last_write.addr});
        @(posedge CLK);
        VPP_PRESENT <= 1'b0;
        twrite(22'h000011, 8'h66, 8'h02);
    endtask

    task automatic t_events();
        logic [5:0] ev [6] = '{6'h20, 6'h01, 6'h04, 6'h02, 6'h08, 6'h10};
        logic [7:0] exp [6] = '{8'h00, 8'h1b, 8'h13, 8'h1f, 8'h0f, 8'h0e};
        foreach (ev[i])
        begin
            @(posedge CLK);
            RESET_EVENTS <= reset_events_t'(ev[i]);
            @(posedge CLK);
            RESET_EVENTS <= '0;
            rd(ADDR_RESET_CAUSE, exp[i]);
            if (i == 0)
                wr(ADDR_RESET_CAUSE, 8'h1f);
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        t_reset_values();
        t_reads();
        t_short_writes();
        t_register();
        t_long_write();
        t_events();
        results();
    end
endmodule
`default_nettype wire
